// ### scrst_chk_sva.sv
// checker for the sensor configuration register block
// assumes it is bound onto scrst_top, one clock domain
`timescale 1ns/1ps
module scrst_chk #(
   parameter DELAY_CYC = 20
) (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // register port
   input wire reg_wr,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata_reg,
   // straps and bus state
   input wire bus_busy,
   input wire boot_mode_strap,
   input wire bus_choice_strap,
   input wire data_lines_tied,
   // outputs watched
   input wire [1:0] selftest_axis_choice_reg,
   input wire selftest_direction_reg,
   input wire [1:0] range_select_reg,
   input wire spi_three_wire_reg,
   input wire irq_polarity_reg,
   input wire soft_reset_reg,
   input wire intf_reset_reg,
   input wire reset_pending_reg,
   input wire miso_oe_reg
);
   reg [15:0] pend_cnt_reg;
   // counts every pending cycle, bus waits included
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) pend_cnt_reg <= 16'h0000;
      else if (!reset_pending_reg) pend_cnt_reg <= 16'h0000;
      // saturates so a long bus wait cannot wrap it
      else if (pend_cnt_reg != 16'hffff)
         pend_cnt_reg <= pend_cnt_reg + 16'h0001;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_rst_reads_zero: assert property (!reg_rdata_reg[7])
      else $error("soft reset bit read back as one");
   a_pend_on_write: assert property (reg_wr && reg_addr == 8'h15
      && reg_wdata[7] |=> reset_pending_reg)
      else $error("reset not pending after write of one");
   a_delay_min: assert property (soft_reset_reg |->
      pend_cnt_reg >= DELAY_CYC)
      else $error("soft reset came too early");
   // bus state at the edge where the delay counter let go
   a_wait_bus: assert property (soft_reset_reg |->
      !$past(bus_busy, 3))
      else $error("soft reset during open transfer");
   a_intf_pair: assert property (
      intf_reset_reg == soft_reset_reg)
      else $error("interface reset not paired");
   a_fields_default: assert property (soft_reset_reg |=>
      selftest_axis_choice_reg == 2'h0 && !selftest_direction_reg
      && range_select_reg == {1'b0, boot_mode_strap})
      else $error("fields not reloaded by soft reset");
   a_retain_irq: assert property (soft_reset_reg |=>
      $stable(irq_polarity_reg))
      else $error("retained bit lost in soft reset");
   a_i2c_four_wire: assert property (!bus_choice_strap &&
      !$past(bus_choice_strap) |-> !spi_three_wire_reg)
      else $error("three-wire with i2c strapped");
   a_tied_three: assert property (bus_choice_strap &&
      data_lines_tied && $past(resetn) &&
      $past(bus_choice_strap && data_lines_tied) |-> spi_three_wire_reg)
      else $error("tied lines not in three-wire");
   a_miso_hiz: assert property (spi_three_wire_reg &&
      $past(spi_three_wire_reg) |-> !miso_oe_reg)
      else $error("data-out pin driven in three-wire");
   c_soft_reset: cover property (soft_reset_reg);
   c_three_wire: cover property (spi_three_wire_reg);
   c_wait_bus: cover property (reset_pending_reg && bus_busy);
endmodule
bind scrst_top scrst_chk #(.DELAY_CYC(DELAY_CYC)) scrst_chk_i (.sys_clk,
   .resetn, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_reg, .bus_busy,
   .boot_mode_strap, .bus_choice_strap, .data_lines_tied,
   .selftest_axis_choice_reg, .selftest_direction_reg, .range_select_reg,
   .spi_three_wire_reg, .irq_polarity_reg, .soft_reset_reg,
   .intf_reset_reg, .reset_pending_reg, .miso_oe_reg);

// ### scrst_defs.vh
// constants for the sensor configuration / soft reset register block
// assumes inclusion by bare name from the design files
`ifndef SCRST_DEFS_VH
`define SCRST_DEFS_VH

`define SCRST_OFFSET 8'h15
`define SCRST_RST_BIT 7
`define SCRST_ST_AXIS_HI 6
`define SCRST_ST_AXIS_LO 5
`define SCRST_SELFTEST_DIRECTION_BIT 4
`define SCRST_SPI_MODE_BIT 3
`define SCRST_RANGE_HI 2
`define SCRST_RANGE_LO 1
`define SCRST_ACTIVE_BIT 0
`define SCRST_RESET_STRAP_LO 8'h00
`define SCRST_RESET_STRAP_HI 8'h03
`define SCRST_ST_OFF 2'h0
`define SCRST_ST_X 2'h1
`define SCRST_ST_Z 2'h2
`define SCRST_CLK_MHZ 40
`define SCRST_DELAY_MIN_US 300
`define SCRST_DELAY_MAX_US 500
`define SCRST_DELAY_CYC ((`SCRST_DELAY_MIN_US) * (`SCRST_CLK_MHZ))
`define SCRST_BOOT_PULSE_CYC 4

`endif

// ### scrst_delay.v
// soft reset delay counter: counts from start to done
// assumes start is a one-cycle pulse; restarts are ignored while busy
`timescale 1ns/1ps
module scrst_delay #(
   parameter WIDTH = 16,
   parameter [WIDTH-1:0] COUNT = 16'h2ee0
) (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // control
   input wire start,
   input wire hold,
   output reg busy_reg,
   output reg done_reg
);
   reg [WIDTH-1:0] cnt_reg;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= {WIDTH{1'b0}};
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (!busy_reg) begin
            if (start) begin
               busy_reg <= 1'b1;
               cnt_reg <= {WIDTH{1'b0}};
            end
         end else if (cnt_reg < COUNT - 1'b1) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (!hold) begin
            // wait past the minimum for the bus to go idle
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end
      end
   end
endmodule

// ### scrst_host.sv
// host side model: keeps a serial transfer open, drives shifter pins
// assumes go is a one-cycle request set on the falling edge
`timescale 1ns/1ps
module scrst_host (
   // clock
   input wire sys_clk,
   // request
   input wire go,
   input wire [7:0] len,
   // towards the device
   output reg bus_busy,
   output reg spi_dout,
   output reg spi_dout_oe
);
   reg [7:0] left_reg;
   initial begin
      bus_busy = 1'b0;
      spi_dout = 1'b0;
      spi_dout_oe = 1'b0;
      left_reg = 8'h00;
   end
   always @(negedge sys_clk) begin
      if (go) left_reg <= len;
      else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
      bus_busy <= go || left_reg > 8'h01;
      // shifter moves only inside a transfer, quiet bus otherwise
      if (bus_busy) spi_dout <= ~spi_dout;
      spi_dout_oe <= bus_busy;
   end
endmodule

// ### scrst_pulse.v
// boot-complete pulse stretcher
// assumes trig is a one-cycle pulse
`timescale 1ns/1ps
module scrst_pulse #(
   parameter LEN = 4
) (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // pulse
   input wire trig,
   output reg pulse_reg
);
   reg [7:0] cnt_reg;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 8'h00;
         pulse_reg <= 1'b0;
      end else if (trig) begin
         cnt_reg <= LEN[7:0];
         pulse_reg <= 1'b1;
      end else if (cnt_reg > 8'h01) begin
         cnt_reg <= cnt_reg - 8'h01;
      end else begin
         cnt_reg <= 8'h00;
         pulse_reg <= 1'b0;
      end
   end
endmodule

// ### scrst_top.v
// sensor configuration register with soft reset, self-test and spi mode
// assumes a register port decoded from the serial interface, synchronous
//
// Contract
// [R01] writing one to bit 7 starts a soft reset in any mode
// [R02] soft reset reloads defaults; irq polarity, drive, boot disable kept
// [R03] host waits the boot time before talking again after reset
// [R04] boot completion is signalled by a pulse on the interrupt pin
// [R05] soft reset also resets the serial interface logic
// [R06] reset waits for i2c stop or spi chip select release
// [R07] soft reset bit always reads back as zero
// [R08] reset sequence begins 300 to 500 us after the bit is set; code holds past the 300 us minimum while the bus is busy, with no 500 us limit
// [R09] self-test axis field: 00 off, 01 x axis, 10 z axis
// [R10] self-test direction bit: 0 positive, 1 negative displacement
// [R11] host ignores data of axes not under self-test
// [R12] host keeps bus traffic low during self-test
// [R13] serial mode bit: 0 four-wire, 1 three-wire spi
// [R14] serial mode bit ignored when i2c is strapped
// [R15] three-wire: data-in pin bidirectional, data-out pin high-z
// [R16] power-on or hibernation exit returns to four-wire spi
// [R17] tied data lines force three-wire spi whatever the bit
// [R18] strap low resets all zero; strap high sets bits 1 and 0
// [R19] range field bits 2..1: 2g, 4g, 8g, 16g
// [R20] bit 0 standby/active; read-only while trigger pin mode control
// [R21] writing zero to bit 7 never cancels a pending reset
`timescale 1ns/1ps
`include "scrst_defs.vh"
module scrst_top #(
   parameter DELAY_CYC = `SCRST_DELAY_CYC,
   parameter BOOT_PULSE_CYC = `SCRST_BOOT_PULSE_CYC
) (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // register port from the serial interface
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_reg,
   // bus activity: i2c between start and stop, or spi chip select low
   input wire bus_busy,
   // straps and system inputs
   input wire boot_mode_strap,
   input wire bus_choice_strap,
   input wire data_lines_tied,
   input wire hibernate_exit,
   input wire trigger_pin_mode_control,
   input wire trigger_pin_level,
   // retained interrupt bits, written by their own register
   input wire irq_polarity_in,
   input wire irq_drive_type_in,
   input wire boot_pulse_disable_in,
   input wire retain_wr,
   // configuration out
   output reg [1:0] selftest_axis_choice_reg,
   output reg selftest_direction_reg,
   output reg [1:0] range_select_reg,
   output reg active_reg,
   output reg spi_three_wire_reg,
   output reg irq_polarity_reg,
   output reg irq_drive_type_reg,
   output reg boot_pulse_disable_reg,
   // reset outputs
   output reg soft_reset_reg,
   output reg intf_reset_reg,
   output reg reset_pending_reg,
   output reg boot_irq_reg,
   // spi data pins
   input wire spi_dout,
   input wire spi_dout_oe,
   output reg mosi_oe_reg,
   output reg mosi_out_reg,
   output reg miso_oe_reg,
   output reg miso_out_reg
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_RESET = 2'd2;
   localparam ST_BOOT = 2'd3;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg spi_m_reg;
   reg strap_seen_reg;
   reg load_defaults;
   reg start_pulse;
   wire delay_busy;
   wire delay_done;
   wire boot_pulse;
   wire sel_wr;
   wire three_wire;
   wire [7:0] default_val;
   wire [7:0] read_val;

   assign sel_wr = reg_wr && (reg_addr == `SCRST_OFFSET);
   assign default_val = boot_mode_strap ? `SCRST_RESET_STRAP_HI :
                        `SCRST_RESET_STRAP_LO; // see [R18]
   // i2c strap makes the mode bit meaningless; tied lines force 3-wire
   assign three_wire = bus_choice_strap &&
                       (spi_m_reg || data_lines_tied); // see [R14] see [R17]
   // bit 7 is never stored, so it reads zero
   assign read_val = {1'b0, selftest_axis_choice_reg,
                      selftest_direction_reg, spi_m_reg,
                      range_select_reg, active_reg}; // see [R07]

   // minimum delay, then hold until the bus is idle
   scrst_delay #(
      .WIDTH(16),
      .COUNT(DELAY_CYC[15:0])
   ) u_delay (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .start(start_pulse),
      .hold(bus_busy),
      .busy_reg(delay_busy),
      .done_reg(delay_done)
   ); // see [R08] see [R06]

   scrst_pulse #(
      .LEN(BOOT_PULSE_CYC)
   ) u_pulse (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .trig(state_reg == ST_BOOT && !boot_pulse_disable_reg),
      .pulse_reg(boot_pulse)
   );

   always @* begin
      state_next = state_reg;
      start_pulse = 1'b0;
      load_defaults = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // accepted in every operating mode, no mode gating
            if (sel_wr && reg_wdata[`SCRST_RST_BIT]) begin // see [R01]
               state_next = ST_WAIT;
               start_pulse = 1'b1;
            end
         end
         ST_WAIT: begin
            // later writes, zero or one, do not touch the pending reset
            if (delay_done) begin // see [R21]
               state_next = ST_RESET;
            end
         end
         ST_RESET: begin
            load_defaults = 1'b1; // see [R02]
            state_next = ST_BOOT;
         end
         ST_BOOT: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // strap is caught by a clock edge after release, not by the reset
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         strap_seen_reg <= 1'b0;
         selftest_axis_choice_reg <= `SCRST_ST_OFF;
         selftest_direction_reg <= 1'b0;
         spi_m_reg <= 1'b0;
         range_select_reg <= 2'h0;
         active_reg <= 1'b0;
      end else if (!strap_seen_reg || load_defaults) begin
         strap_seen_reg <= 1'b1;
         selftest_axis_choice_reg <= default_val[6:5];
         selftest_direction_reg <= default_val[`SCRST_SELFTEST_DIRECTION_BIT];
         range_select_reg <= default_val[2:1];
         active_reg <= default_val[`SCRST_ACTIVE_BIT]; // see [R18]
         spi_m_reg <= default_val[`SCRST_SPI_MODE_BIT];
      end else if (hibernate_exit) begin
         spi_m_reg <= 1'b0; // see [R16]
      end else if (sel_wr) begin
         selftest_axis_choice_reg <=
            reg_wdata[`SCRST_ST_AXIS_HI:`SCRST_ST_AXIS_LO]; // see [R09]
         selftest_direction_reg <= reg_wdata[`SCRST_SELFTEST_DIRECTION_BIT]; // see [R10]
         spi_m_reg <= reg_wdata[`SCRST_SPI_MODE_BIT]; // see [R13]
         range_select_reg <=
            reg_wdata[`SCRST_RANGE_HI:`SCRST_RANGE_LO]; // see [R19]
         if (!trigger_pin_mode_control) begin
            active_reg <= reg_wdata[`SCRST_ACTIVE_BIT]; // see [R20]
         end
      end else if (trigger_pin_mode_control) begin
         active_reg <= trigger_pin_level; // see [R20]
      end
   end

   // retained bits are untouched by the soft reset
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_polarity_reg <= 1'b0;
         irq_drive_type_reg <= 1'b0;
         boot_pulse_disable_reg <= 1'b0;
      end else if (retain_wr) begin // see [R02]
         irq_polarity_reg <= irq_polarity_in;
         irq_drive_type_reg <= irq_drive_type_in;
         boot_pulse_disable_reg <= boot_pulse_disable_in;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_reg <= 8'h00;
         soft_reset_reg <= 1'b0;
         intf_reset_reg <= 1'b0;
         reset_pending_reg <= 1'b0;
         boot_irq_reg <= 1'b0;
         spi_three_wire_reg <= 1'b0;
         mosi_oe_reg <= 1'b0;
         mosi_out_reg <= 1'b0;
         miso_oe_reg <= 1'b0;
         miso_out_reg <= 1'b0;
      end else begin
         if (reg_rd && reg_addr == `SCRST_OFFSET) begin
            reg_rdata_reg <= read_val;
         end
         soft_reset_reg <= load_defaults;
         intf_reset_reg <= load_defaults; // see [R05]
         reset_pending_reg <= (state_next != ST_IDLE);
         // active level follows the configured polarity
         boot_irq_reg <= boot_pulse ^ ~irq_polarity_reg; // see [R04]
         spi_three_wire_reg <= three_wire;
         // 3-wire: reply on the data-in pin, data-out pin floats
         mosi_oe_reg <= three_wire & spi_dout_oe; // see [R15]
         mosi_out_reg <= three_wire & spi_dout;
         miso_oe_reg <= ~three_wire & bus_choice_strap & spi_dout_oe;
         miso_out_reg <= ~three_wire & spi_dout;
      end
   end
endmodule

// ### tb_scrst_top.sv
// bench for the sensor configuration register block
// assumes scrst_top with a shortened reset delay
`timescale 1ns/1ps
module tb_scrst_top;
   reg sys_clk, resetn, reg_wr, reg_rd, boot_mode_strap, bus_choice_strap;
   reg data_lines_tied, hibernate_exit, trigger_pin_mode_control;
   reg trigger_pin_level, irq_polarity_in, retain_wr, go;
   reg [7:0] reg_addr, reg_wdata, rd_val;
   reg [7:0] vals [0:3];
   wire [7:0] reg_rdata_reg;
   wire [1:0] axis, range;
   wire dir, act, three, pol, drv, bdis, srst, irst, pend, birq;
   wire busy, dout, dout_oe, mosi_oe, mosi_out, miso_oe, miso_out;
   integer n_mismatch, num_checks, i, cnt;
   scrst_top #(.DELAY_CYC(20), .BOOT_PULSE_CYC(4)) scrst_top_i (
      .sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_reg(reg_rdata_reg), .bus_busy(busy),
      .boot_mode_strap(boot_mode_strap),
      .bus_choice_strap(bus_choice_strap),
      .data_lines_tied(data_lines_tied), .hibernate_exit(hibernate_exit),
      .trigger_pin_mode_control(trigger_pin_mode_control),
      .trigger_pin_level(trigger_pin_level),
      .irq_polarity_in(irq_polarity_in),
      .irq_drive_type_in(irq_polarity_in),
      .boot_pulse_disable_in(1'b0), .retain_wr(retain_wr),
      .selftest_axis_choice_reg(axis), .selftest_direction_reg(dir),
      .range_select_reg(range), .active_reg(act),
      .spi_three_wire_reg(three), .irq_polarity_reg(pol),
      .irq_drive_type_reg(drv), .boot_pulse_disable_reg(bdis),
      .soft_reset_reg(srst), .intf_reset_reg(irst),
      .reset_pending_reg(pend), .boot_irq_reg(birq), .spi_dout(dout),
      .spi_dout_oe(dout_oe), .mosi_oe_reg(mosi_oe),
      .mosi_out_reg(mosi_out), .miso_oe_reg(miso_oe),
      .miso_out_reg(miso_out));
   scrst_host scrst_host_i (.sys_clk(sys_clk), .go(go), .len(8'h3c),
      .bus_busy(busy), .spi_dout(dout), .spi_dout_oe(dout_oe));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task chk(input [8*8-1:0] name, input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge sys_clk);
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         cyc(1);
         reg_wr = 1'b0;
      end
   endtask
   task rd;
      begin
         reg_addr = 8'h15;
         reg_rd = 1'b1;
         cyc(1);
         reg_rd = 1'b0;
         cyc(1);
         rd_val = reg_rdata_reg;
      end
   endtask
   task do_reset;
      begin
         resetn = 1'b0;
         cyc(5);
         resetn = 1'b1;
         cyc(2);
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   initial begin
      {resetn, reg_wr, reg_rd, boot_mode_strap, bus_choice_strap} = 5'h00;
      {data_lines_tied, hibernate_exit, trigger_pin_mode_control} = 3'h0;
      {trigger_pin_level, irq_polarity_in, retain_wr, go} = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      n_mismatch = 0;
      num_checks = 0;
      vals[0] = 8'h22; vals[1] = 8'h54; vals[2] = 8'h06; vals[3] = 8'h08;
      cyc(1);
      do_reset;
      rd;
      chk("rst_lo", rd_val, 8'h00);
      // no axis data is read while self-test is set
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h15, vals[i]);
         rd;
         chk("readback", rd_val, vals[i]);
         chk("axis", axis, vals[i][6:5]);
         chk("dir", dir, vals[i][4]);
         chk("range", range, vals[i][2:1]);
      end
      chk("i2c_mode", three, 8'h00);
      wr(8'h16, 8'hff);
      rd;
      chk("unmapped", rd_val, 8'h08);
      bus_choice_strap = 1'b1;
      cyc(2);
      chk("three", three, 8'h01);
      chk("miso_oe", miso_oe, 8'h00);
      hibernate_exit = 1'b1;
      cyc(1);
      hibernate_exit = 1'b0;
      rd;
      chk("hib_exit", rd_val, 8'h00);
      chk("four", three, 8'h00);
      // three-wire transfer: reply goes out on the data-in pin
      data_lines_tied = 1'b1;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(2);
      chk("tied", three, 8'h01);
      chk("mosi_oe", mosi_oe, 8'h01);
      chk("miso_oe", miso_oe, 8'h00);
      chk("mosi_out", mosi_out, dout);
      data_lines_tied = 1'b0;
      trigger_pin_mode_control = 1'b1;
      wr(8'h15, 8'h01);
      // looked at right after the write, before the pin can mask it
      chk("act_ro", act, 8'h00);
      trigger_pin_level = 1'b1;
      cyc(2);
      chk("act_pin", act, 8'h01);
      trigger_pin_mode_control = 1'b0;
      trigger_pin_level = 1'b0;
      boot_mode_strap = 1'b1;
      irq_polarity_in = 1'b1;
      retain_wr = 1'b1;
      cyc(1);
      retain_wr = 1'b0;
      wr(8'h15, 8'h54);
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(2);
      chk("miso_oe", miso_oe, 8'h01);
      chk("mosi_oe", mosi_oe, 8'h00);
      chk("miso_out", miso_out, dout);
      // reset bit plus the other fields in one write
      wr(8'h15, 8'hd4);
      rd;
      chk("rst_rd", rd_val, 8'h54);
      wr(8'h15, 8'h00);
      chk("pending", pend, 8'h01);
      cnt = 0;
      while (srst !== 1'b1 && cnt < 300) begin
         cyc(1);
         cnt = cnt + 1;
      end
      chk("srst", srst, 8'h01);
      chk("irst", irst, 8'h01);
      chk("bus_wait", cnt > 40, 8'h01);
      cnt = 0;
      // host stays off the bus until the boot pulse
      while (birq !== 1'b1 && cnt < 100) begin
         cyc(1);
         cnt = cnt + 1;
      end
      chk("boot_irq", birq, 8'h01);
      cnt = 0;
      while (birq === 1'b1 && cnt < 20) begin
         cyc(1);
         cnt = cnt + 1;
      end
      chk("boot_len", cnt, 8'h04);
      chk("pend_end", pend, 8'h00);
      rd;
      chk("defaults", rd_val, 8'h03);
      chk("retained", pol, 8'h01);
      chk("drv_kept", drv, 8'h01);
      chk("bdis", bdis, 8'h00);
      do_reset;
      rd;
      chk("rst_hi", rd_val, 8'h03);
      results;
   end
endmodule
